// ==== inc/supv_map.vh ====
// Constants for the supply supervisor event logic: reset values and timing.
`ifndef SUPV_MAP_VH
`define SUPV_MAP_VH
`define CLK_MHZ            40
`define RIE_RESET          16'h1100
`define RIE_LOW_POR_BIT    8
`define RIE_HIGH_POR_BIT   12
`define REG_CMD_SWITCHED   2'h2
`define MASK_TIME_US       2
`define STALL_SLOW_US      150
`define STALL_FAST_US      2
`define MASK_CYC           (`MASK_TIME_US * `CLK_MHZ)
`define STALL_SLOW_CYC     (`STALL_SLOW_US * `CLK_MHZ)
`define STALL_FAST_CYC     (`STALL_FAST_US * `CLK_MHZ)
`define LPM_ACTIVE         3'h0
`define LPM_TWO            3'h2
`define LPM_THREE          3'h3
`define LPM_FOUR           3'h4
`endif

// ==== src/cycle_timer.v ====
// Down-counting delay timer with a one-cycle done pulse and busy level.
`timescale 1ns/1ps
module cycle_timer #(
  parameter W = 13
) (
  input  wire         clk,
  input  wire         srst,
  input  wire         start,     // Loads the count; restarts if running.
  input  wire [W-1:0] load_val,  // Cycles to run, at least one.
  output reg          busy_ff,   // High while the count runs.
  output reg          done_ff    // One-cycle pulse when the count ends.
);
  reg [W-1:0] cnt_ff;            // Remaining cycles.

  // A restart while running simply reloads, so the latest request wins, long or short.
  always @(posedge clk) begin
    if (srst) begin
      cnt_ff  <= {W{1'b0}};
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (start) begin
      cnt_ff  <= load_val;
      busy_ff <= 1'b1;
      done_ff <= 1'b0;
    end else if (busy_ff) begin
      if (cnt_ff <= {{(W-1){1'b0}}, 1'b1}) begin
        busy_ff <= 1'b0;
        done_ff <= 1'b1;
      end else begin
        done_ff <= 1'b0;
      end
      cnt_ff <= cnt_ff - {{(W-1){1'b0}}, 1'b1};
    end else begin
      done_ff <= 1'b0;
    end
  end
endmodule // cycle_timer

// ==== src/supply_supervisor_event_logic.v ====
// Supply supervisor and monitor event, flag and reset-request logic.
// Behaviour
// - Hold supervisor events during DMA, then deliver.
// - Brownout sets both POR enables, value 1100h.
// - Switched reference in deep sleep or command 10b.
// - Switched reference, high mode bit clear: no events.
// - Mask events 2 us after full-performance re-enable.
// - Wake stall 150 us normal, else 2 us.
// - Mode bit clear: comparators off in deep sleep.
// - Power-up clear or POR re-enables both supervisors.
// - Trip sets flag; POR if side enabled.
// - Tri-state GPIO while supervisor flags set and unsettled.
// - Control write after power-up clear re-arms flags.
// - Exit flag writable; vector read clears it.
`timescale 1ns/1ps
`include "supv_map.vh"
module supply_supervisor_event_logic #(
  parameter TW = 13
) (
  input  wire        clk,
  input  wire        srst,             // Brownout reset.
  input  wire        power_up_clear,   // One-cycle soft reset pulse.
  input  wire [2:0]  lpm_mode,         // Current low-power mode, 0 = active.
  input  wire        dma_active,       // DMA transfer in progress.
  input  wire [1:0]  cmp_trip,         // Raw comparator trips, [1]=high.
  input  wire [1:0]  mon_trip,         // Raw monitor trips, [1]=high.
  input  wire [1:0]  supervisor_lowpower_mode_bit, // [1]=high side.
  input  wire [1:0]  supervisor_full_performance,  // [1]=high side.
  input  wire        low_monitor_full_performance,
  input  wire        low_monitor_enable,
  input  wire [1:0]  sup_enable_wr,    // Software enable write data.
  input  wire [1:0]  ctl_write,        // Write strobe to side's control reg.
  input  wire [1:0]  regulator_command_field,
  input  wire        regulator_command_wr,
  input  wire        rie_wr,           // Write to reset/interrupt enable.
  input  wire [15:0] rie_wdata,
  input  wire [1:0]  flag_clear,       // Software clears trip flags.
  input  wire [1:0]  mon_flag_clear,   // Software clears monitor flags.
  input  wire        exit_flag_wr,     // Write to the deep-sleep exit flag.
  input  wire        exit_flag_wdata,
  input  wire        deep_sleep_exit,  // Hardware wake from deepest sleep.
  input  wire        vector_read,      // Reset vector word entry read.
  output reg  [15:0] reset_interrupt_enable_reg,
  output reg  [1:0]  supervisor_trip_flag,
  output reg  [1:0]  monitor_trip_flag,
  output reg         deep_sleep_exit_flag,
  output reg         por_request_ff,   // One-cycle power-on reset request.
  output reg         irq_event_ff,     // One-cycle interrupt event.
  output reg         gpio_hiz_ff,      // All GPIO forced high impedance.
  output reg         cpu_stall_ff,     // CPU held after wake from mode three or four.
  output reg         switched_ref_ff,  // Regulator reference is switched.
  output reg  [1:0]  cmp_on_ff         // Comparator power, per side.
);
  // Timer loads in clock cycles. The counts are worked out as integers and
  // then cut to the timer width on purpose; TW must stay wide enough for
  // the long wake stall, or the stall would silently wrap to a short one.
  localparam integer MASK_I = `MASK_CYC;       // Event mask length.
  localparam integer SLOW_I = `STALL_SLOW_CYC; // Stall, normal mode.
  localparam integer FAST_I = `STALL_FAST_CYC; // Stall, fast wake.
  localparam [TW-1:0] MASK_LD = MASK_I[TW-1:0];
  localparam [TW-1:0] SLOW_LD = SLOW_I[TW-1:0];
  localparam [TW-1:0] FAST_LD = FAST_I[TW-1:0];

  // Deep low-power modes two to four. Both the comparator power-down and
  // the switched reference hang off this one decode, so the two can never
  // disagree about which modes count as deep.
  function deep_lpm;
    input [2:0] m;
    begin
      deep_lpm = (m >= `LPM_TWO) && (m <= `LPM_FOUR);
    end
  endfunction

  // Internal state. Bit 1 is always the high side and bit 0 the low side,
  // matching the pairing of every two-bit port except regulator_command_field.
  reg [1:0] sup_en_ff;      // Supervisor enabled per side.
  reg [1:0] armed_ff;       // Flag function armed per side.
  reg [1:0] pend_sup_ff;    // Held supervisor events.
  reg [1:0] pend_mon_ff;    // Held monitor events.
  reg       cmd_sw_ff;      // Software asked for switched reference.
  reg [2:0] lpm_ff;         // Previous mode, for wake detection.
  reg [1:0] nxt_cmp_on;
  wire      mask_busy;
  wire      stall_busy;
  wire      deep_now  = deep_lpm(lpm_mode);
  wire      wake      = deep_lpm(lpm_ff) && (lpm_mode == `LPM_ACTIVE);
  wire      wake_34   = wake && (lpm_ff == `LPM_THREE ||
                                 lpm_ff == `LPM_FOUR);

  // Comparators follow enable, dropping in deep sleep without mode bit.
  // Powering them down saves sleep current, at the price of a settling
  // period on every wake; setting the mode bit trades the other way.
  always @* begin
    nxt_cmp_on = sup_en_ff & ~({2{deep_now}} &
                               ~supervisor_lowpower_mode_bit);
  end

  // Re-enable in full performance starts the event mask.
  wire [1:0] reon       = nxt_cmp_on & ~cmp_on_ff;
  wire       mask_start = |(reon & supervisor_full_performance);
  // Low side slow unless both parts are off or in full performance.
  wire low_fast = (~sup_en_ff[0] & ~low_monitor_enable) |
                  (supervisor_full_performance[0] &
                   low_monitor_full_performance);
  wire [TW-1:0] stall_ld = low_fast ? FAST_LD : SLOW_LD;

  // Event mask timer. Only a re-enable in full performance starts it; a
  // normal-mode comparator settles behind its own longer delay.
  cycle_timer #(.W(TW)) u_mask (
    .clk      (clk),
    .srst     (srst),
    .start    (mask_start),
    .load_val (MASK_LD),
    .busy_ff  (mask_busy),
    .done_ff  ()
  );

  // Wake stall timer. It starts on the cycle the mode returns to active
  // from three or four; the load is chosen from the low side settings.
  cycle_timer #(.W(TW)) u_stall (
    .clk      (clk),
    .srst     (srst),
    .start    (wake_34),
    .load_val (stall_ld),
    .busy_ff  (stall_busy),
    .done_ff  ()
  );

  // Events are suppressed in switched mode with the high mode bit clear.
  // The mask gates the same path, so a blocked trip is dropped, not held:
  // only a DMA transfer parks events for later delivery.
  wire evt_block = (switched_ref_ff & ~supervisor_lowpower_mode_bit[1]) |
                   mask_busy;
  wire [1:0] sup_evt = cmp_trip & cmp_on_ff & armed_ff &
                       {2{~evt_block}};
  wire [1:0] mon_evt = mon_trip & armed_ff & {2{~evt_block}};
  wire [1:0] all_sup = sup_evt | pend_sup_ff;
  wire [1:0] all_mon = mon_evt | pend_mon_ff;
  wire [1:0] por_en  = {reset_interrupt_enable_reg[`RIE_HIGH_POR_BIT],
                        reset_interrupt_enable_reg[`RIE_LOW_POR_BIT]};

  // Main state: enables, arming, pending events, flags and outputs.
  // Everything shares one process so that every output leaves a flip-flop
  // and a flag set and its clear are resolved in one place.
  always @(posedge clk) begin
    if (srst) begin
      reset_interrupt_enable_reg <= `RIE_RESET;
      sup_en_ff            <= 2'h3;
      armed_ff             <= 2'h3;
      pend_sup_ff          <= 2'h0;
      pend_mon_ff          <= 2'h0;
      supervisor_trip_flag <= 2'h0;
      monitor_trip_flag    <= 2'h0;
      deep_sleep_exit_flag <= 1'b0;
      por_request_ff       <= 1'b0;
      irq_event_ff         <= 1'b0;
      gpio_hiz_ff          <= 1'b0;
      cpu_stall_ff         <= 1'b0;
      switched_ref_ff      <= 1'b0;
      cmd_sw_ff            <= 1'b0;
      cmp_on_ff            <= 2'h0;
      lpm_ff               <= `LPM_ACTIVE;
    end else begin
      lpm_ff    <= lpm_mode;
      cmp_on_ff <= nxt_cmp_on;
      if (regulator_command_wr) begin
        cmd_sw_ff <= (regulator_command_field == `REG_CMD_SWITCHED);
      end
      switched_ref_ff <= deep_now | cmd_sw_ff;
      if (rie_wr) begin
        reset_interrupt_enable_reg <= rie_wdata;
      end
      // Power-up clear turns supervisors on; software may change later.
      if (power_up_clear) begin
        sup_en_ff <= 2'h3;
        // Flag function drops for any side that was off before.
        armed_ff  <= armed_ff & sup_en_ff;
      end else begin
        sup_en_ff <= (sup_en_ff & ~ctl_write) | (sup_enable_wr & ctl_write);
        armed_ff  <= armed_ff | ctl_write;
      end
      // During DMA events are parked; none is dropped.
      // Parked events merge per side, so two trips of one side during a
      // long transfer come out as a single delivery.
      if (dma_active) begin
        pend_sup_ff          <= all_sup;
        pend_mon_ff          <= all_mon;
        por_request_ff       <= 1'b0;
        irq_event_ff         <= 1'b0;
      end else begin
        pend_sup_ff    <= 2'h0;
        pend_mon_ff    <= 2'h0;
        por_request_ff <= |(all_sup & por_en);
        irq_event_ff   <= |(all_sup | all_mon);
      end
      // Set beats clear so a trip in the clear cycle stays visible.
      // A vector read clears both sides of both flag sets at once.
      supervisor_trip_flag <= (supervisor_trip_flag &
                               ~(flag_clear | {2{vector_read}})) |
                              (dma_active ? 2'h0 : all_sup);
      monitor_trip_flag    <= (monitor_trip_flag &
                               ~(mon_flag_clear | {2{vector_read}})) |
                              (dma_active ? 2'h0 : all_mon);
      // Exit flag: hardware set wins over read clear and write.
      // Software learns of the flag only through the vector word read.
      if (deep_sleep_exit) begin
        deep_sleep_exit_flag <= 1'b1;
      end else if (exit_flag_wr) begin
        deep_sleep_exit_flag <= exit_flag_wdata;
      end else if (vector_read) begin
        deep_sleep_exit_flag <= 1'b0;
      end
      // Pins float while a supervisor flag is up and comparators still settle.
      // The start term covers the first cycle, before the timer is busy.
      gpio_hiz_ff  <= (|supervisor_trip_flag) &
                      (mask_busy | mask_start);
      // The cycle after the wake stalls too, so no instruction slips through
      // while the timer loads.
      cpu_stall_ff <= stall_busy | wake_34;
    end
  end
endmodule // supply_supervisor_event_logic

// ==== testbench/supv_event_checker_assertions.sv ====
// Port-level assertions for the supply supervisor event logic.
`timescale 1ns/1ps
module supv_event_checker (
  input logic        clk,
  input logic        srst,
  input logic [2:0]  lpm_mode,
  input logic        dma_active,
  input logic [1:0]  supervisor_lowpower_mode_bit,
  input logic [1:0]  regulator_command_field,
  input logic        regulator_command_wr,
  input logic [1:0]  flag_clear,
  input logic        vector_read,
  input logic [15:0] reset_interrupt_enable_reg,
  input logic [1:0]  supervisor_trip_flag,
  input logic        por_request_ff,
  input logic        irq_event_ff,
  input logic        cpu_stall_ff,
  input logic        switched_ref_ff,
  input logic [1:0]  cmp_on_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Any of the deep modes, and the step back to active from three or four.
  sequence deep_s;
    lpm_mode inside {3'h2, 3'h3, 3'h4};
  endsequence
  sequence wake_s;
    lpm_mode == 3'h0 && $past(lpm_mode) inside {3'h3, 3'h4};
  endsequence
  a_reset_value: assert property (
    $fell(srst) |-> reset_interrupt_enable_reg == 16'h1100)
    else $error("bad reset value");
  a_por_needs_enable: assert property (
    por_request_ff |-> $past(reset_interrupt_enable_reg[8] |
                             reset_interrupt_enable_reg[12]))
    else $error("por without enable");
  a_dma_holds: assert property (
    $past(dma_active) |-> !irq_event_ff && !por_request_ff)
    else $error("event during dma");
  a_flag_holds: assert property (
    supervisor_trip_flag[0] && !flag_clear[0] && !vector_read
    |=> supervisor_trip_flag[0])
    else $error("flag lost");
  a_cmd_switch: assert property (
    regulator_command_wr && regulator_command_field == 2'h2
    |-> ##2 switched_ref_ff)
    else $error("no switched ref");
  a_no_event: assert property (
    switched_ref_ff && !supervisor_lowpower_mode_bit[1]
    |=> !$rose(supervisor_trip_flag[1]))
    else $error("event while switched");
  a_wake_stall: assert property (
    wake_s |=> cpu_stall_ff)
    else $error("no stall on wake");
  a_cmp_off: assert property (
    deep_s ##0 !supervisor_lowpower_mode_bit[0] |=> !cmp_on_ff[0])
    else $error("comparator left on");
endmodule // supv_event_checker
bind supply_supervisor_event_logic supv_event_checker u_chk (
  .clk                          (clk),
  .srst                         (srst),
  .lpm_mode                     (lpm_mode),
  .dma_active                   (dma_active),
  .supervisor_lowpower_mode_bit (supervisor_lowpower_mode_bit),
  .regulator_command_field      (regulator_command_field),
  .regulator_command_wr         (regulator_command_wr),
  .flag_clear                   (flag_clear),
  .vector_read                  (vector_read),
  .reset_interrupt_enable_reg   (reset_interrupt_enable_reg),
  .supervisor_trip_flag         (supervisor_trip_flag),
  .por_request_ff               (por_request_ff),
  .irq_event_ff                 (irq_event_ff),
  .cpu_stall_ff                 (cpu_stall_ff),
  .switched_ref_ff              (switched_ref_ff),
  .cmp_on_ff                    (cmp_on_ff)
);

// ==== testbench/test_supply_supervisor_event_logic.sv ====
// Self-checking bench for the supply supervisor event logic.
`timescale 1ns/1ps
module test_supply_supervisor_event_logic;
  logic clk = 1'b0, srst = 1'b1, power_up_clear, dma_active, rie_wr;
  logic low_monitor_full_performance, low_monitor_enable, vector_read;
  logic regulator_command_wr, exit_flag_wr, exit_flag_wdata, deep_sleep_exit;
  logic deep_sleep_exit_flag, por_request_ff, irq_event_ff, gpio_hiz_ff;
  logic cpu_stall_ff, switched_ref_ff;
  logic [1:0] cmp_trip, mon_trip, supervisor_lowpower_mode_bit, ctl_write;
  logic [1:0] supervisor_full_performance, sup_enable_wr, flag_clear;
  logic [1:0] regulator_command_field, mon_flag_clear, monitor_trip_flag;
  logic [1:0] supervisor_trip_flag, cmp_on_ff;
  logic [2:0] lpm_mode;
  logic [15:0] rie_wdata, reset_interrupt_enable_reg;
  int n_errors = 0, cmp_count = 0, n;
  supply_supervisor_event_logic uut (.*);
  always #12.5 clk = ~clk;
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(int k);
    repeat (k) @(negedge clk);
  endtask
  // One-cycle strobe; inputs only move on the falling edge.
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  task automatic trip(logic [1:0] s);
    cmp_trip = s;
    cyc(1);
    cmp_trip = 2'h0;
  endtask
  // Sleep in mode three, wake, then count the stalled cycles in n.
  task automatic wake();
    lpm_mode = 3'h3;
    cyc(3);
    // A side whose low-power mode bit is set keeps its comparator on.
    chk("cmp_on", {14'h0, supervisor_lowpower_mode_bit}, cmp_on_ff);
    lpm_mode = 3'h0;
    cyc(1);
    n = 0;
    while (cpu_stall_ff !== 1'b0 && n < 7000) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic t_events();
    chk("rie", 16'h1100, reset_interrupt_enable_reg);
    trip(2'h1);
    chk("por", 16'h1, por_request_ff);
    chk("irq", 16'h1, irq_event_ff);
    cyc(4);
    chk("flag", 16'h1, supervisor_trip_flag);
    rie_wdata = 16'h0000;
    pulse(rie_wr);
    trip(2'h2);
    chk("flag", 16'h3, supervisor_trip_flag);
    chk("por", 16'h0, por_request_ff);
    dma_active = 1'b1;
    pulse(vector_read);
    trip(2'h1);
    cyc(3);
    chk("flag", 16'h0, supervisor_trip_flag);
    chk("irq", 16'h0, irq_event_ff);
    dma_active = 1'b0;
    cyc(1);
    chk("irq", 16'h1, irq_event_ff);
    chk("flag", 16'h1, supervisor_trip_flag);
  endtask
  task automatic t_exit();
    pulse(deep_sleep_exit);
    chk("exit", 16'h1, deep_sleep_exit_flag);
    pulse(vector_read);
    chk("exit", 16'h0, deep_sleep_exit_flag);
    chk("flag", 16'h0, supervisor_trip_flag);
    exit_flag_wdata = 1'b1;
    pulse(exit_flag_wr);
    chk("exit", 16'h1, deep_sleep_exit_flag);
  endtask
  // Switched reference blocks events; full performance shortens the stall.
  task automatic t_power();
    regulator_command_field = 2'h2;
    pulse(regulator_command_wr);
    cyc(1);
    chk("ref", 16'h1, switched_ref_ff);
    trip(2'h2);
    chk("flag", 16'h0, supervisor_trip_flag);
    wake();
    chk("slow", 16'h1, n > 5990 && n < 6010);
    supervisor_full_performance = 2'h1;
    low_monitor_full_performance = 1'b1;
    supervisor_lowpower_mode_bit = 2'h2;
    wake();
    chk("fast", 16'h1, n > 70 && n < 90);
    lpm_mode = 3'h3;
    cyc(3);
    lpm_mode = 3'h0;
    cyc(2);
    trip(2'h1);
    chk("mask", 16'h0, supervisor_trip_flag);
    cyc(100);
    trip(2'h1);
    chk("mask", 16'h1, supervisor_trip_flag);
    // With a flag up, the next settling period floats the pins.
    lpm_mode = 3'h3;
    cyc(3);
    lpm_mode = 3'h0;
    cyc(2);
    chk("hiz", 16'h1, gpio_hiz_ff);
    cyc(100);
    chk("hiz", 16'h0, gpio_hiz_ff);
  endtask
  // A side switched off before a power-up clear stays disarmed until written.
  task automatic t_rearm();
    supervisor_full_performance = 2'h0;
    sup_enable_wr = 2'h0;
    ctl_write = 2'h1;
    pulse(vector_read);
    ctl_write = 2'h0;
    pulse(power_up_clear);
    cyc(2);
    chk("cmp_on", 16'h3, cmp_on_ff);
    trip(2'h1);
    chk("flag", 16'h0, supervisor_trip_flag);
    sup_enable_wr = 2'h3;
    ctl_write = 2'h1;
    cyc(1);
    ctl_write = 2'h0;
    trip(2'h1);
    chk("flag", 16'h1, supervisor_trip_flag);
  endtask
  // Monitor trips set their own flag; software clears each flag set.
  task automatic t_clear();
    mon_trip = 2'h2;
    cyc(1);
    mon_trip = 2'h0;
    chk("irq", 16'h1, irq_event_ff);
    chk("mflag", 16'h2, monitor_trip_flag);
    cyc(3);
    chk("mflag", 16'h2, monitor_trip_flag);
    mon_flag_clear = 2'h2;
    flag_clear = 2'h1;
    cyc(1);
    {mon_flag_clear, flag_clear} = 4'h0;
    chk("mflag", 16'h0, monitor_trip_flag);
    chk("flag", 16'h0, supervisor_trip_flag);
    regulator_command_field = 2'h0;
    pulse(regulator_command_wr);
    cyc(1);
    chk("ref", 16'h0, switched_ref_ff);
  endtask
  task automatic finish_test();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    {power_up_clear, dma_active, rie_wr, low_monitor_full_performance,
     vector_read, regulator_command_wr, exit_flag_wr, exit_flag_wdata,
     deep_sleep_exit, cmp_trip, mon_trip, supervisor_lowpower_mode_bit,
     ctl_write, supervisor_full_performance, sup_enable_wr, flag_clear,
     regulator_command_field, mon_flag_clear, lpm_mode, rie_wdata} = '0;
    low_monitor_enable = 1'b1;
    cyc(10);
    srst = 1'b0;
    // Comparators power up on the first edge after release, so the first
    // trip waits until they are on.
    cyc(2);
    t_events();
    t_exit();
    t_power();
    t_rearm();
    t_clear();
    finish_test();
  end
  // The whole run needs about 6350 cycles; this cuts a hang well past that.
  initial begin
    #500us;
    n_errors++;
    finish_test();
  end
endmodule // test_supply_supervisor_event_logic
